// ===== hdl/lcdpfs_map.vh
`ifndef LCDPFS_MAP_VH
`define LCDPFS_MAP_VH
// Byte offsets of the word registers on the register bus.
`define LCDPFS_OFS_MASTER    4'h0
`define LCDPFS_OFS_COM_ROLE  4'h4
`define LCDPFS_OFS_SEG_LOW   4'h8
`define LCDPFS_OFS_SEG_MID   4'hC
`define LCDPFS_OFS_STATUS    5'h10
// Field positions.
`define LCDPFS_BIT_MASTER_EN 0
`define LCDPFS_BIT_CRYSTAL   1
`define LCDPFS_BIT_LINE5_EN  7
`define LCDPFS_BIT_LINE4_EN  6
`define LCDPFS_BIT_LINE0_EN  2
// Reset values.
`define LCDPFS_RST_REG       8'h00
`define LCDPFS_RST_MASTER    2'h0
`endif

// ===== hdl/lcdpfs_route.v
`timescale 1ns/10ps
`default_nettype none
module lcdpfs_route (
   // Selections
   input  wire        master_en_i,
   input  wire [5:0]  line_lcd_en_i,
   input  wire [5:0]  line_role_i,
   input  wire [15:0] seg_en_i,
   input  wire        crystal_sel_i,
   // Pin functions
   output wire [5:0]  line_common_o,
   output wire [5:0]  line_segment_o,
   output wire [15:0] seg_lcd_o
);
   wire [5:0] line_on;
   wire [1:0] osc_keep;

   assign line_on        = master_en_i ? line_lcd_en_i : 6'h00;
   assign line_common_o  = line_on & ~line_role_i;
   assign line_segment_o = line_on & line_role_i;
   // Crystal pins must never be driven by the LCD, so the crystal choice wins.
   assign osc_keep       = crystal_sel_i ? 2'h0 : 2'h3;
   assign seg_lcd_o      = master_en_i ? (seg_en_i & {6'h3F, osc_keep, 8'hFF}) : 16'h0000;
endmodule
`default_nettype wire

// ===== hdl/lcdpfs_top.v
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "lcdpfs_map.vh"
module lcdpfs_top (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output wire        ack_o,
   // Lines 0 to 3 hand-off from the first control register
   input  wire [3:0]  line_low_lcd_en_i,
   // Pin functions
   output wire [5:0]  line_common_o,
   output wire [5:0]  line_segment_o,
   output wire [15:0] seg_lcd_o
);
   ////////////////////////////////////////////////////////////////////////////
   reg  [1:0]  master_reg;
   reg  [7:0]  com_role_reg;
   reg  [7:0]  seg_low_reg;
   reg  [7:0]  seg_mid_reg;
   reg         ack_reg;
   wire        req;
   wire        wr;

   assign req   = cyc_i & stb_i & ~ack_reg;
   assign wr    = req & we_i & sel_i[0];
   assign ack_o = ack_reg;

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   always @(posedge clk_i) begin
      if (rst_i) begin
         master_reg   <= `LCDPFS_RST_MASTER;
         com_role_reg <= `LCDPFS_RST_REG;
         seg_low_reg  <= `LCDPFS_RST_REG;
         seg_mid_reg  <= `LCDPFS_RST_REG;
         ack_reg      <= 1'b0;
         dat_o        <= 32'h00000000;
      end else begin
         ack_reg <= req;
         if (wr && hit(adr_i, {4'h0, `LCDPFS_OFS_MASTER})) begin
            master_reg <= dat_i[1:0];
         end else if (wr && hit(adr_i, {4'h0, `LCDPFS_OFS_COM_ROLE})) begin
            com_role_reg <= dat_i[7:0];
         end else if (wr && hit(adr_i, {4'h0, `LCDPFS_OFS_SEG_LOW})) begin
            seg_low_reg <= dat_i[7:0];
         end else if (wr && hit(adr_i, {4'h0, `LCDPFS_OFS_SEG_MID})) begin
            seg_mid_reg <= dat_i[7:0];
         end
         // Unmapped addresses still ack and read zero so the bus never hangs.
         if (hit(adr_i, {4'h0, `LCDPFS_OFS_MASTER})) begin
            dat_o <= {30'h00000000, master_reg};
         end else if (hit(adr_i, {4'h0, `LCDPFS_OFS_COM_ROLE})) begin
            dat_o <= {24'h000000, com_role_reg};
         end else if (hit(adr_i, {4'h0, `LCDPFS_OFS_SEG_LOW})) begin
            dat_o <= {24'h000000, seg_low_reg};
         end else if (hit(adr_i, {4'h0, `LCDPFS_OFS_SEG_MID})) begin
            dat_o <= {24'h000000, seg_mid_reg};
         end else if (hit(adr_i, {3'h0, `LCDPFS_OFS_STATUS})) begin
            dat_o <= {16'h0000, seg_lcd_o};
         end else begin
            dat_o <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   lcdpfs_route u_route (
      .master_en_i    (master_reg[`LCDPFS_BIT_MASTER_EN]),
      .line_lcd_en_i  ({com_role_reg[`LCDPFS_BIT_LINE5_EN], com_role_reg[`LCDPFS_BIT_LINE4_EN],
                        line_low_lcd_en_i}),
      .line_role_i    (com_role_reg[5:0]),
      .seg_en_i       ({seg_mid_reg, seg_low_reg}),
      .crystal_sel_i  (master_reg[`LCDPFS_BIT_CRYSTAL]),
      .line_common_o  (line_common_o),
      .line_segment_o (line_segment_o),
      .seg_lcd_o      (seg_lcd_o)
   );
endmodule
`default_nettype wire

// ===== verification/lcdpfs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module lcdpfs_sva (
   input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i, line_low_lcd_en_i,
   input wire logic [31:0] dat_i, dat_o,
   input wire logic [5:0]  line_common_o, line_segment_o,
   input wire logic [15:0] seg_lcd_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_one: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
   a_role_excl: assert property (!(line_common_o & line_segment_o)) else $error("two roles");
   a_low_lines: assert property (((line_common_o[3:0] | line_segment_o[3:0]) & ~line_low_lcd_en_i) == 4'h0)
      else $error("line 0 to 3 without enable");
   a_reset_clear: assert property (disable iff (1'b0) rst_i |=> seg_lcd_o == 16'h0000) else $error("no clear");
   a_status_read: assert property (ack_o && !we_i && adr_i == 8'h10 |-> dat_o == {16'h0000, seg_lcd_o})
      else $error("status differs");
   a_seg_cause: assert property ($changed(seg_lcd_o) |-> $rose(ack_o) && $past(we_i && sel_i[0]))
      else $error("segment moved alone");
   a_upper_cause: assert property ($changed(line_common_o[5:4] | line_segment_o[5:4]) |-> ack_o)
      else $error("upper line moved alone");
   c_write: cover property (ack_o && we_i);
   c_seg_osc: cover property (seg_lcd_o[9:8] != 2'h0);
   c_line5_seg: cover property (line_segment_o[5]);
endmodule
bind lcdpfs_top lcdpfs_sva chk (.*);
`default_nettype wire

// ===== verification/test_lcd_pin_function_select.sv
`timescale 1ns/10ps
`default_nettype none
module test_lcd_pin_function_select;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0, line_low_lcd_en_i = 4'h0;
   logic [31:0] dat_i = 32'h0, rd;
   wire  [31:0] dat_o;
   wire         ack_o;
   wire  [5:0]  line_common_o, line_segment_o;
   wire  [15:0] seg_lcd_o;
   int          failures = 0, checks_done = 0, tick = 0, m[4] = '{0, 0, 0, 0};
   lcdpfs_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .line_low_lcd_en_i(line_low_lcd_en_i),
      .line_common_o(line_common_o), .line_segment_o(line_segment_o), .seg_lcd_o(seg_lcd_o));
   initial forever #12.5 clk_i = ~clk_i;
   // A hang in the handshake ends here rather than at the simulator limit.
   always @(posedge clk_i) if (++tick > 5000) begin failures++; conclude(); end
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (e !== g) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end
   endtask
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge clk_i); cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o; cyc_i <= 0; stb_i <= 0;
      if (w && s[0] && a < 8'h10) m[a >> 2] = d[7:0] & (a == 8'h00 ? 3 : 255);
   endtask
   function automatic logic [15:0] es();
      return m[0][0] ? {m[3][7:0], m[2][7:0]} & (m[0][1] ? 16'hFCFF : 16'hFFFF) : 16'h0000;
   endfunction
   task automatic cmp();
      logic [5:0] en;
      en = m[0][0] ? {m[1][7:6], line_low_lcd_en_i} : 6'h00;
      #1 chk("seg", es(), seg_lcd_o);
      chk("com", en & ~m[1][5:0], line_common_o);
      chk("segl", en & m[1][5:0], line_segment_o);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hf2f24c50));
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      cmp();
      for (int i = 0; i < 4; i++) begin wb(0, 8'(i * 4), 0, 1); chk("rst", 0, rd); end
      // Random sel also exercises dropped writes with lane 0 off.
      repeat (60) begin
         wb(1, 8'(4 * ($urandom % 6)), $urandom, 4'($urandom));
         line_low_lcd_en_i <= 4'($urandom);
         @(posedge clk_i);
         cmp();
         for (int i = 0; i < 4; i++) begin wb(0, 8'(i * 4), 0, 1); chk("rd", m[i], rd); end
         wb(0, 8'h10, 0, 1); chk("st", {16'h0, es()}, rd);
         wb(0, 8'h14, 0, 1); chk("unm", 0, rd);
      end
      conclude();
   end
endmodule
`default_nettype wire
